/* File: src/ieb_bank.sv */
// One bank of 32 lines: enable and pending state with set and clear strobes
`timescale 1ns/1ps
module ieb_bank (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic [ieb_pkg::BANK_W-1:0]  line_in,
  input  wire logic [ieb_pkg::DATA_W-1:0]  wmask,
  input  wire logic                        en_set_we,
  input  wire logic                        en_clr_we,
  input  wire logic                        pd_set_we,
  input  wire logic                        pd_clr_we,
  output logic      [ieb_pkg::BANK_W-1:0]  enable,
  output logic      [ieb_pkg::BANK_W-1:0]  pending,
  output logic      [ieb_pkg::BANK_W-1:0]  rise
);
  import ieb_pkg::*;

  ieb_bank_state_t st_reg;   // Registered bank state
  ieb_bank_state_t st_next;  // Next bank state
  logic [31:0]     set_mask; // Bits going pending this cycle
  logic [31:0]     clr_mask; // Bits cleared by software

  // Next-state logic; zero bits of a write leave state alone
  always_comb begin
    st_next  = st_reg;
    rise     = line_in & ~st_reg.line_prev;
    set_mask = rise | (pd_set_we ? wmask : RST_PENDING);
    clr_mask = pd_clr_we ? wmask : RST_PENDING;
    st_next.line_prev = line_in;
    if (en_set_we) begin
      st_next.enable = st_reg.enable | wmask;
    end else if (en_clr_we) begin
      st_next.enable = st_reg.enable & ~wmask;
    end
    // A line edge in the clearing cycle still wins, so no event is lost
    st_next.pending = (st_reg.pending & ~clr_mask) | set_mask;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= RST_BANK;
    end else begin
      st_reg <= st_next;
    end
  end

  assign enable  = st_reg.enable;
  assign pending = st_reg.pending;

endmodule

/* File: src/ieb_decode.sv */
// Address decoder: maps an APB byte address to a register view and bank
`timescale 1ns/1ps
module ieb_decode (
  input  wire logic [ieb_pkg::ADDR_W-1:0] addr,
  output ieb_pkg::ieb_sel_t               sel,
  output logic                            bank
);
  import ieb_pkg::*;

  // Word compare only; the two low address bits are ignored
  always_comb begin
    sel  = IEB_SEL_NONE;
    bank = 1'b0;
    case (addr[11:2])
      OFF_PRIV_EN_SET[11:2], OFF_PRIV_EN_CLR[11:2],
      OFF_PRIV_PD_SET[11:2], OFF_PRIV_PD_CLR[11:2]: begin
        sel = IEB_SEL_RSVD;  // Private slots answer but hold nothing
      end
      OFF_LO_EN_SET[11:2]: sel = IEB_SEL_EN_SET;
      OFF_LO_EN_CLR[11:2]: sel = IEB_SEL_EN_CLR;
      OFF_LO_PD_SET[11:2]: sel = IEB_SEL_PD_SET;
      OFF_LO_PD_CLR[11:2]: sel = IEB_SEL_PD_CLR;
      OFF_UP_EN_SET[11:2]: begin
        sel  = IEB_SEL_EN_SET;
        bank = 1'b1;
      end
      OFF_UP_EN_CLR[11:2]: begin
        sel  = IEB_SEL_EN_CLR;
        bank = 1'b1;
      end
      OFF_UP_PD_SET[11:2]: begin
        sel  = IEB_SEL_PD_SET;
        bank = 1'b1;
      end
      OFF_UP_PD_CLR[11:2]: begin
        sel  = IEB_SEL_PD_CLR;
        bank = 1'b1;
      end
      default: begin
        sel  = IEB_SEL_NONE;  // Unmapped: slave error
        bank = 1'b0;
      end
    endcase
  end

endmodule

/* File: src/ieb_enable_pending_bank.sv */
// APB enable/pending bank for external interrupt lines 32 to 95
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module ieb_enable_pending_bank (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ieb_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [ieb_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [ieb_pkg::STRB_W-1:0]  pstrb,
  output logic      [ieb_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [ieb_pkg::LINES-1:0]   ext_irq_in,
  output logic      [ieb_pkg::LINES-1:0]   line_enable,
  output logic      [ieb_pkg::LINES-1:0]   line_pending
);
  import ieb_pkg::*;

  ieb_apb_state_t st_reg;                 // Registered slave state
  ieb_apb_state_t st_next;                // Next slave state
  ieb_sel_t       sel;                    // Register view under the address
  logic           bank;                   // 0 lower, 1 upper
  logic           setup_cyc;              // First cycle of a transfer
  logic           wr_fire;                // Write takes effect this edge
  logic [31:0]    wmask;                  // Write data gated by strobes
  logic [31:0]    rd_mux;                 // Read data of the current address
  logic [31:0]    enable_vec  [BANKS];    // Enable state per bank
  logic [31:0]    pending_vec [BANKS];    // Pending state per bank
  logic [31:0]    rise_vec    [BANKS];    // Line rising edges per bank
  logic [BANKS-1:0] en_set_we;            // Per-bank write strobes
  logic [BANKS-1:0] en_clr_we;
  logic [BANKS-1:0] pd_set_we;
  logic [BANKS-1:0] pd_clr_we;

  // Address decode of the eight bank views and the private slots
  ieb_decode u_decode (
    .addr (paddr),
    .sel  (sel),
    .bank (bank)
  );

  // Handshake terms
  assign setup_cyc = psel && !penable;
  // Zero wait states: the access phase after every setup is ready
  assign pready    = psel && penable && (st_reg.phase == IEB_PH_ACCESS);
  assign pslverr   = pready && st_reg.err;
  assign prdata    = st_reg.rdata;
  assign wr_fire   = pready && pwrite && !st_reg.err;

  // Byte strobes: unstrobed lanes write zeros, which leave state alone
  always_comb begin
    wmask = pwdata;
    for (int i = 0; i < STRB_W; i++) begin
      if (!pstrb[i]) begin
        wmask[i*8 +: 8] = 8'h00;
      end
    end
  end

  // Banks: lower holds lines 32..63, upper lines 64..95
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    // Strobes only fire on the completing edge of a mapped write
    assign en_set_we[b] = wr_fire && (sel == IEB_SEL_EN_SET) && (bank == b[0]);
    assign en_clr_we[b] = wr_fire && (sel == IEB_SEL_EN_CLR) && (bank == b[0]);
    assign pd_set_we[b] = wr_fire && (sel == IEB_SEL_PD_SET) && (bank == b[0]);
    assign pd_clr_we[b] = wr_fire && (sel == IEB_SEL_PD_CLR) && (bank == b[0]);

    ieb_bank u_bank (
      .pclk      (pclk),
      .presetn   (presetn),
      .line_in   (ext_irq_in[b*BANK_W +: BANK_W]),
      .wmask     (wmask),
      .en_set_we (en_set_we[b]),
      .en_clr_we (en_clr_we[b]),
      .pd_set_we (pd_set_we[b]),
      .pd_clr_we (pd_clr_we[b]),
      .enable    (enable_vec[b]),
      .pending   (pending_vec[b]),
      .rise      (rise_vec[b])
    );

    // Bit k of bank b is line base + k, in order
    assign line_enable[b*BANK_W +: BANK_W]  = enable_vec[b];
    assign line_pending[b*BANK_W +: BANK_W] = pending_vec[b];
  end

  // Read mux: set and clear views return the same stored vector
  always_comb begin
    rd_mux = RSVD_RDATA;
    case (sel)
      IEB_SEL_EN_SET: rd_mux = enable_vec[bank];
      IEB_SEL_EN_CLR: rd_mux = enable_vec[bank];
      IEB_SEL_PD_SET: rd_mux = pending_vec[bank];
      IEB_SEL_PD_CLR: rd_mux = pending_vec[bank];
      IEB_SEL_RSVD:   rd_mux = RSVD_RDATA;
      default:        rd_mux = RSVD_RDATA;
    endcase
  end

  // Slave next state; read data is sampled in the setup cycle so that
  // prdata comes from a flop, at the cost of showing the state one cycle old
  always_comb begin
    st_next = st_reg;
    case (st_reg.phase)
      IEB_PH_IDLE: begin
        if (setup_cyc) begin
          st_next.phase = IEB_PH_ACCESS;
          st_next.rdata = pwrite ? RSVD_RDATA : rd_mux;
          st_next.err   = (sel == IEB_SEL_NONE);
        end
      end
      IEB_PH_ACCESS: begin
        // A setup may not overlap an access; leave once it completes
        if (pready) begin
          st_next.phase = IEB_PH_IDLE;
        end else if (!psel) begin
          st_next.phase = IEB_PH_IDLE;  // Master abandoned the transfer
        end
      end
      default: begin
        st_next = RST_APB;
      end
    endcase
  end

  // Slave state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= RST_APB;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---- Assertions ----

  // Setup cycle is always followed by a ready access phase
  zero_wait_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_cyc ##1 (psel && penable)) |-> pready)
    else $error("access phase not ready after setup");

  // Enable-set write turns on every written bit
  en_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    en_set_we[0] |=> ((enable_vec[0] & $past(wmask)) == $past(wmask)))
    else $error("enable-set write did not enable lines");

  // Enable-clear write turns off every written bit
  en_clr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    en_clr_we[1] |=> ((enable_vec[1] & $past(wmask)) == 32'h0000_0000))
    else $error("enable-clear write did not disable lines");

  // Pending-set write makes every written bit pending
  pd_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pd_set_we[1] |=> ((pending_vec[1] & $past(wmask)) == $past(wmask)))
    else $error("pending-set write did not set pending");

  // Pending-clear write clears bits that saw no edge that cycle
  pd_clr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pd_clr_we[0] |=>
      ((pending_vec[0] & $past(wmask) & ~$past(rise_vec[0])) == 32'h0000_0000))
    else $error("pending-clear write left lines pending");

  // A line edge in the clearing cycle is not lost
  edge_wins_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pd_clr_we[1] |=> ((pending_vec[1] & $past(rise_vec[1])) == $past(rise_vec[1])))
    else $error("line edge lost against pending clear");

  // Zero bits of an enable-set write keep their old state
  set_keep_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    en_set_we[1] |=>
      ((enable_vec[1] & ~$past(wmask)) == ($past(enable_vec[1]) & ~$past(wmask))))
    else $error("enable-set write changed unwritten bits");

  // Zero bits of an enable-clear write keep their old state
  clr_keep_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    en_clr_we[0] |=>
      ((enable_vec[0] | $past(wmask)) == ($past(enable_vec[0]) | $past(wmask))))
    else $error("enable-clear write changed unwritten bits");

  // Upper enable-set read returns the enable vector
  rd_en_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && sel == IEB_SEL_EN_SET && bank) |-> (prdata == enable_vec[1]))
    else $error("enable-set read mismatch");

  // Lower enable-clear read returns the same enable vector
  rd_en_clr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && sel == IEB_SEL_EN_CLR && !bank) |-> (prdata == enable_vec[0]))
    else $error("enable-clear read mismatch");

  // Pending views return the pending vector sampled in setup
  rd_pend_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && (sel == IEB_SEL_PD_SET || sel == IEB_SEL_PD_CLR))
      |-> (prdata == $past(pending_vec[bank])))
    else $error("pending read mismatch");

  // Private slots read zero and answer without error
  rsvd_slot_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && sel == IEB_SEL_RSVD) |-> (!pslverr && (pwrite || prdata == 32'h0000_0000)))
    else $error("private slot misbehaved");

  // Unmapped addresses get a slave error
  unmapped_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && sel == IEB_SEL_NONE) |-> pslverr)
    else $error("unmapped address without error");

  // All lines disabled and idle right after reset
  reset_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> (line_enable == 64'h0 && line_pending == 64'h0))
    else $error("state not zero after reset");

  // Upper line edge becomes upper pending bit one cycle later
  upper_map_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 ((line_pending[63:32] & $past(rise_vec[1])) == $past(rise_vec[1])))
    else $error("upper line edge not recorded");

  // Lower line edge becomes lower pending bit one cycle later
  lower_map_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 ((line_pending[31:0] & $past(rise_vec[0])) == $past(rise_vec[0])))
    else $error("lower line edge not recorded");

  // Enable state moves only through bus writes
  en_stable_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(|en_set_we || |en_clr_we) |=> $stable(line_enable))
    else $error("enable changed without a write");

  // Upper enable-set write turns on every written bit
  up_en_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    en_set_we[1] |=> ((enable_vec[1] & $past(wmask)) == $past(wmask)))
    else $error("upper enable-set write did not enable lines");

  // Lower enable-clear write turns off every written bit
  lo_en_clr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    en_clr_we[0] |=> ((enable_vec[0] & $past(wmask)) == 32'h0000_0000))
    else $error("lower enable-clear write did not disable lines");

  // Lower pending-set write makes every written bit pending
  lo_pd_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pd_set_we[0] |=> ((pending_vec[0] & $past(wmask)) == $past(wmask)))
    else $error("lower pending-set write did not set pending");

  // Upper pending-clear write clears bits that saw no edge that cycle
  up_pd_clr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pd_clr_we[1] |=>
      ((pending_vec[1] & $past(wmask) & ~$past(rise_vec[1])) == 32'h0000_0000))
    else $error("upper pending-clear write left lines pending");

  // A lower line edge in the clearing cycle is not lost
  lo_edge_wins_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pd_clr_we[0] |=> ((pending_vec[0] & $past(rise_vec[0])) == $past(rise_vec[0])))
    else $error("lower line edge lost against pending clear");

  // Zero bits of a lower enable-set write keep their old state
  lo_set_keep_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    en_set_we[0] |=>
      ((enable_vec[0] & ~$past(wmask)) == ($past(enable_vec[0]) & ~$past(wmask))))
    else $error("lower enable-set write changed unwritten bits");

  // Unstrobed byte lanes never reach the banks
  strb_mask_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_fire |-> ((wmask & ~{{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}})
                 == 32'h0000_0000))
    else $error("unstrobed lane reached a bank");

  // Pending bits fall only through a pending-clear write
  pd_keep_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(|pd_clr_we) |=> ((~line_pending & $past(line_pending)) == 64'h0))
    else $error("pending cleared without a write");

  // Lower enable-set read returns the enable vector
  rd_lo_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && sel == IEB_SEL_EN_SET && !bank) |-> (prdata == enable_vec[0]))
    else $error("lower enable-set read mismatch");

  // Upper enable-clear read returns the same enable vector
  rd_up_clr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && sel == IEB_SEL_EN_CLR && bank) |-> (prdata == enable_vec[1]))
    else $error("upper enable-clear read mismatch");

  // Writes return zero read data
  wr_rdata_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && pwrite) |-> (prdata == 32'h0000_0000))
    else $error("write returned read data");

  // Ready only in the cycle after a setup
  ready_slot_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |-> $past(setup_cyc))
    else $error("ready outside an access phase");

  // An unmapped write leaves the enables alone
  bad_wr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && pwrite && sel == IEB_SEL_NONE) |=> $stable(line_enable))
    else $error("unmapped write changed enables");

endmodule

/* File: src/ieb_pkg.sv */
// Constants and types shared by the interrupt enable/pending bank files
package ieb_pkg;

  // Bus and bank geometry
  localparam int unsigned ADDR_W     = 12;          // Byte address width of the 4 KB window
  localparam int unsigned DATA_W     = 32;          // APB data width
  localparam int unsigned STRB_W     = 4;           // APB byte strobes
  localparam int unsigned BANK_W     = 32;          // Lines per bank register
  localparam int unsigned BANKS      = 2;           // Lower and upper banks
  localparam int unsigned LINES      = 64;          // External lines held here
  localparam int unsigned LOWER_LINE = 32;          // First line of the lower bank
  localparam int unsigned UPPER_LINE = 64;          // First line of the upper bank

  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_PRIV_EN_SET   = 12'h100;  // Private slot, reads zero
  localparam logic [11:0] OFF_LO_EN_SET     = 12'h104;
  localparam logic [11:0] OFF_UP_EN_SET     = 12'h108;
  localparam logic [11:0] OFF_PRIV_EN_CLR   = 12'h180;  // lower_private_enable_clear
  localparam logic [11:0] OFF_LO_EN_CLR     = 12'h184;
  localparam logic [11:0] OFF_UP_EN_CLR     = 12'h188;
  localparam logic [11:0] OFF_PRIV_PD_SET   = 12'h200;  // lower_private_pending_set
  localparam logic [11:0] OFF_LO_PD_SET     = 12'h204;
  localparam logic [11:0] OFF_UP_PD_SET     = 12'h208;
  localparam logic [11:0] OFF_PRIV_PD_CLR   = 12'h280;  // lower_private_pending_clear
  localparam logic [11:0] OFF_LO_PD_CLR     = 12'h284;
  localparam logic [11:0] OFF_UP_PD_CLR     = 12'h288;

  // Reset values
  localparam logic [31:0] RST_ENABLE  = 32'h0000_0000;
  localparam logic [31:0] RST_PENDING = 32'h0000_0000;
  localparam logic [31:0] RST_LINES   = 32'h0000_0000;
  localparam logic [31:0] RST_RDATA   = 32'h0000_0000;
  localparam logic [31:0] RSVD_RDATA  = 32'h0000_0000;

  // Register view selected by an address
  typedef enum logic [2:0] {
    IEB_SEL_NONE   = 3'h0,
    IEB_SEL_RSVD   = 3'h1,
    IEB_SEL_EN_SET = 3'h2,
    IEB_SEL_EN_CLR = 3'h3,
    IEB_SEL_PD_SET = 3'h4,
    IEB_SEL_PD_CLR = 3'h5
  } ieb_sel_t;

  // APB slave phase, Gray coded
  typedef enum logic [1:0] {
    IEB_PH_IDLE   = 2'h0,
    IEB_PH_ACCESS = 2'h1
  } ieb_phase_t;

  // State of one bank
  typedef struct packed {
    logic [31:0] enable;
    logic [31:0] pending;
    logic [31:0] line_prev;
  } ieb_bank_state_t;

  // State of the bus slave
  typedef struct packed {
    ieb_phase_t  phase;
    logic [31:0] rdata;
    logic        err;
  } ieb_apb_state_t;

  localparam ieb_bank_state_t RST_BANK = '{RST_ENABLE, RST_PENDING, RST_LINES};
  localparam ieb_apb_state_t  RST_APB  = '{IEB_PH_IDLE, RST_RDATA, 1'b0};

endpackage

/* File: tb/ieb_enable_pending_bank_tb.sv */
// Self-checking bench for the enable/pending bank of lines 32 to 95
`timescale 1ns/1ps
module ieb_enable_pending_bank_tb;
  import ieb_pkg::*;

  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wd;
    logic [31:0] rd;
    logic        err;
  } ieb_row_t;

  logic        pclk;         // 250 MHz bus clock
  logic        presetn;      // Active-low reset
  logic        psel;         // APB select
  logic        penable;      // APB enable
  logic        pwrite;       // APB direction
  logic [11:0] paddr;        // APB byte address
  logic [31:0] pwdata;       // APB write data
  logic [3:0]  pstrb;        // Byte strobes
  logic [31:0] prdata;       // Read data seen
  logic        pready;       // Transfer completion
  logic        pslverr;      // Error response
  logic [63:0] ext_irq_in;   // Lines from the source model
  logic [63:0] line_enable;  // Enable state seen
  logic [63:0] line_pending; // Pending state seen
  logic [63:0] fire;         // Requests to the source model
  logic [63:0] en_m;         // Expected enable vector
  logic [63:0] pd_m;         // Expected pending vector
  logic [31:0] rd;           // Last read word
  logic        er;           // Last error response
  int          miscompares;
  int          check_count;
  int          cycles = 0;

  // Enable values avoid the reserved lower and upper bits
  localparam int NROWS = 24;
  ieb_row_t rows [NROWS] = '{
    '{1, 12'h104, 32'h0000_0013, 32'h0, 0}, '{0, 12'h104, 32'h0, 32'h0000_0013, 0},
    '{0, 12'h184, 32'h0, 32'h0000_0013, 0}, '{1, 12'h108, 32'h0000_8001, 32'h0, 0},
    '{0, 12'h188, 32'h0, 32'h0000_8001, 0}, '{1, 12'h184, 32'h0000_0001, 32'h0, 0},
    '{0, 12'h104, 32'h0, 32'h0000_0012, 0}, '{1, 12'h188, 32'h0000_8000, 32'h0, 0},
    '{0, 12'h108, 32'h0, 32'h0000_0001, 0}, '{1, 12'h204, 32'ha5a5_0000, 32'h0, 0},
    '{0, 12'h284, 32'h0, 32'ha5a5_0000, 0}, '{1, 12'h284, 32'h0500_0000, 32'h0, 0},
    '{0, 12'h204, 32'h0, 32'ha0a5_0000, 0}, '{1, 12'h208, 32'h8000_0001, 32'h0, 0},
    '{0, 12'h288, 32'h0, 32'h8000_0001, 0}, '{1, 12'h288, 32'h8000_0001, 32'h0, 0},
    '{0, 12'h208, 32'h0, 32'h0, 0},         '{0, 12'h180, 32'h0, 32'h0, 0},
    '{1, 12'h200, 32'hffff_ffff, 32'h0, 0}, '{1, 12'h280, 32'hffff_ffff, 32'h0, 0},
    '{0, 12'h284, 32'h0, 32'ha0a5_0000, 0}, '{0, 12'h300, 32'h0, 32'h0, 1},
    '{1, 12'h10c, 32'hffff_ffff, 32'h0, 1}, '{0, 12'h104, 32'h0, 32'h0000_0012, 0}
  };
  logic [11:0] views [6] = '{12'h104, 12'h108, 12'h184, 12'h188, 12'h204, 12'h284};

  ieb_enable_pending_bank u_ieb_enable_pending_bank (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_in(ext_irq_in), .line_enable(line_enable),
    .line_pending(line_pending)
  );

  ieb_irq_source u_ieb_irq_source (
    .pclk(pclk), .presetn(presetn), .fire(fire), .irq_lines(ext_irq_in)
  );

  // Free-running bus clock, 4 ns period
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Prints the counts and the verdict, then stops the run
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles >= 5000) begin
      miscompares++;
      close_out();
    end
  end

  // Compares a seen value with the expected one
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready as long as it takes, only the hang guard ends it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic erv);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    check({63'h0, pready}, 64'h0);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Expected effect of a write: set views OR in ones, clear views AND them out
  task automatic model_write(input logic [11:0] a, input logic [31:0] wd);
    case (a)
      OFF_LO_EN_SET: en_m[31:0]  = en_m[31:0] | wd;
      OFF_UP_EN_SET: en_m[63:32] = en_m[63:32] | wd;
      OFF_LO_EN_CLR: en_m[31:0]  = en_m[31:0] & ~wd;
      OFF_UP_EN_CLR: en_m[63:32] = en_m[63:32] & ~wd;
      OFF_LO_PD_SET: pd_m[31:0]  = pd_m[31:0] | wd;
      OFF_UP_PD_SET: pd_m[63:32] = pd_m[63:32] | wd;
      OFF_LO_PD_CLR: pd_m[31:0]  = pd_m[31:0] & ~wd;
      OFF_UP_PD_CLR: pd_m[63:32] = pd_m[63:32] & ~wd;
      default: ;
    endcase
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
    pwdata = 32'h0; pstrb = 4'hf; fire = 64'h0; en_m = 64'h0; pd_m = 64'h0;
    miscompares = 0; check_count = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check(line_enable, 64'h0);
    // Table of ordinary accesses, with line outputs checked after each
    for (int i = 0; i < NROWS; i++) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wd, rd, er);
      check({32'h0, rd}, {32'h0, rows[i].rd});
      check({63'h0, er}, {63'h0, rows[i].err});
      model_write(rows[i].addr, rows[i].wd);
      @(negedge pclk);
      check(line_enable, en_m);
      check(line_pending, pd_m);
    end
    $display("test table done");
    // Peripheral edges on line 40 and line 90 land in the right banks
    @(posedge pclk);
    fire <= 64'h0400_0000_0000_0100;
    @(posedge pclk);
    fire <= 64'h0;
    for (int n = 0; n < 10 && !(line_pending[8] === 1'b1 && line_pending[58] === 1'b1); n++) begin
      @(negedge pclk);
    end
    pd_m = pd_m | 64'h0400_0000_0000_0100;
    check(line_pending, pd_m);
    apb(1'b0, OFF_UP_PD_SET, 32'h0, rd, er);
    check({32'h0, rd}, {32'h0, pd_m[63:32]});
    apb(1'b0, OFF_LO_PD_CLR, 32'h0, rd, er);
    check({32'h0, rd}, {32'h0, pd_m[31:0]});
    $display("test line edges done");
    // Upper pending-clear in the very cycle of a line 74 edge: edge wins, bit 26 clears
    fork
      apb(1'b1, OFF_UP_PD_CLR, 32'h0400_0400, rd, er);
      begin
        @(posedge pclk);
        fire <= 64'h0000_0400_0000_0000;
        @(posedge pclk);
        fire <= 64'h0;
      end
    join
    model_write(OFF_UP_PD_CLR, 32'h0400_0400);
    pd_m[42] = 1'b1;
    @(negedge pclk);
    check(line_pending, pd_m);
    $display("test clear against edge done");
    // Read-modify-write of the upper enable keeps the bits already set
    apb(1'b0, OFF_UP_EN_SET, 32'h0, rd, er);
    apb(1'b1, OFF_UP_EN_SET, rd | 32'h0000_0010, rd, er);
    en_m[63:32] = en_m[63:32] | 32'h0000_0010;
    @(negedge pclk);
    check(line_enable, en_m);
    $display("test read modify write done");
    // Only lane 0 strobed: bit 5 sets, the one in lane 2 must be dropped
    @(posedge pclk);
    pstrb <= 4'h1;
    apb(1'b1, OFF_LO_EN_SET, 32'h0010_0020, rd, er);
    pstrb <= 4'hf;
    en_m[31:0] = en_m[31:0] | 32'h0000_0020;
    @(negedge pclk);
    check(line_enable, en_m);
    $display("test byte strobes done");
    // Second reset in mid-run clears both line vectors and the six views read back
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check(line_enable, 64'h0);
    check(line_pending, 64'h0);
    foreach (views[k]) begin
      apb(1'b0, views[k], 32'h0, rd, er);
      check({32'h0, rd}, 64'h0);
    end
    $display("test reset done");
    close_out();
  end
endmodule

/* File: tb/ieb_irq_source.sv */
// Peripheral interrupt line model that feeds the enable/pending bank
`timescale 1ns/1ps
module ieb_irq_source (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [63:0] fire,
  output logic      [63:0] irq_lines
);
  logic [63:0] stage_a_reg; // First cycle of a request
  logic [63:0] stage_b_reg; // Second cycle of a request

  // A one-cycle fire pulse becomes a two-cycle high level on the line.
  // Two cycles rather than one so the bank's edge detector sees a
  // stable level, not a glitch; the line then falls back low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_a_reg <= 64'h0;
      stage_b_reg <= 64'h0;
    end else begin
      stage_a_reg <= fire;
      stage_b_reg <= stage_a_reg;
    end
  end

  // Lines are idle low between requests and after reset
  assign irq_lines = stage_a_reg | stage_b_reg;
endmodule
